// file: design/bie_defs.svh
// constants of the bus interface error detector: widths, offsets, bits, counts
// included by the package and by every file that uses its macros; definitions only
`ifndef BIE_DEFS_SVH
`define BIE_DEFS_SVH
// widths
`define BIE_AW 32
`define BIE_TAG_W 16
`define BIE_STAT_W 3
`define BIE_CTL_W 4
`define BIE_ERR_W 14
// register byte offsets
`define BIE_OFF_STATUS 5'h00
`define BIE_OFF_MASK 5'h04
`define BIE_OFF_CAPADDR 5'h08
`define BIE_OFF_CAPSTATE 5'h0C
// error status bit positions
`define BIE_E_NXMRD 0
`define BIE_E_NXMWR 1
`define BIE_E_CPE 2
`define BIE_E_CONTROL_TRANSMIT_CHECK_ERROR 3
`define BIE_E_DROP 4
`define BIE_E_COL 5
`define BIE_E_TAGPE 6
`define BIE_E_STATPE 7
`define BIE_E_SHR 8
`define BIE_E_DRT 9
`define BIE_E_STALL 10
`define BIE_E_CNFE 11
`define BIE_E_CA 12
`define BIE_E_SUM 13
// captured state fields
`define BIE_CS_HELD 31
`define BIE_CS_OPWR 3
`define BIE_CS_SHR 2
`define BIE_CS_DRT 1
// cache line status field: shared flag
`define BIE_LS_SHARED 1
// control line positions
`define BIE_CL_ARB 0
`define BIE_CL_CMD 1
`define BIE_CL_WR 2
`define BIE_CL_DATA 3
// reset values
`define BIE_MASK_RST 14'h0000
// timing counts in clk_sys cycles
`define BIE_CNF_TIMEOUT 8
`define BIE_XFER_CYCLES 2
`endif

// file: design/bie_error_detect.sv
// bus interface error detector: request sequencer, error flags, capture
// assumes all inputs synchronous to clk_sys and an Avalon-MM master
`timescale 1ns/1ps
`default_nettype none
`include "bie_defs.svh"
module bie_error_detect
    import bie_pkg::*;
#(
    parameter int unsigned CNF_TIMEOUT = `BIE_CNF_TIMEOUT,
    parameter int unsigned XFER_CYCLES = `BIE_XFER_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire bie_cpu_req_t cpuReq,
    output var bie_cycle_acknowledge_t cpuCack,
    input wire bie_cache_t cacheIn,
    input wire bie_bus_in_t busIn,
    input wire logic [`BIE_CTL_W-1:0] ctlIn,
    output logic [`BIE_CTL_W-1:0] ctlOut,
    output logic [`BIE_CTL_W-1:0] ctlOe,
    output logic [`BIE_AW-1:0] busAddr,
    output logic irq
);
    bie_state_t stFf; // sequencer state
    bie_state_t nxtSt; // next sequencer state
    logic opWrFf; // current bus op is a write
    logic [`BIE_AW-1:0] curAddrFf; // address of request in flight
    logic [3:0] cntFf; // confirm wait / transfer counter
    logic [`BIE_CTL_W-1:0] ctlOutFf; // control lines asserted
    logic [`BIE_CTL_W-1:0] nxtCtl; // control lines for next state
    logic [`BIE_ERR_W-1:0] statusFf; // sticky error flags
    logic [`BIE_ERR_W-1:0] nxtStatus; // next sticky flags
    logic [`BIE_ERR_W-1:0] errSet; // errors seen this cycle
    logic [`BIE_ERR_W-1:0] maskFf; // interrupt enables
    logic heldFf; // capture registers frozen
    logic [`BIE_AW-1:0] capAddrFf; // captured bus address
    logic [3:0] capStFf; // captured op and responses
    logic waitFf; // waitrequest flop
    logic [31:0] rdataFf; // read data flop
    logic irqFf; // interrupt flop
    bie_cycle_acknowledge_t cackFf; // acknowledge flop
    logic tagErr; // tag parity mismatch
    logic statErr; // status parity mismatch
    logic cnfTimeout; // confirm window over
    logic xferLast; // last data cycle
    logic busPhase; // commander owns the bus
    logic acc; // access taken this edge
    logic clrHeld; // software releases capture
    logic [`BIE_ERR_W-1:0] clrBits; // write-one-to-clear bits

    // parity checks on the lookup result
    bie_parity_chk #(.W(`BIE_TAG_W)) uTagChk (
        .data(cacheIn.tag),
        .par(cacheIn.tagPar),
        .err(tagErr)
    );
    bie_parity_chk #(.W(`BIE_STAT_W)) uStatChk (
        .data(cacheIn.stat),
        .par(cacheIn.statPar),
        .err(statErr)
    );

    assign cnfTimeout = (cntFf == 4'(CNF_TIMEOUT - 1));
    assign xferLast = (cntFf == 4'(XFER_CYCLES - 1));
    assign busPhase = (stFf == BIE_CMD) || (stFf == BIE_CNF) || (stFf == BIE_XFER);

    // error detection for the current cycle
    always_comb begin
        errSet = '0;
        // no confirmation inside the window
        errSet[`BIE_E_NXMRD] = (stFf == BIE_CNF) && !opWrFf && cnfTimeout
            && !busIn.confirm;
        errSet[`BIE_E_NXMWR] = (stFf == BIE_CNF) && opWrFf && cnfTimeout
            && !busIn.confirm;
        // parity error reported during our command or confirm phase
        errSet[`BIE_E_CPE] = ((stFf == BIE_CMD) || (stFf == BIE_CNF))
            && busIn.cmdParErr;
        // any line we pull that the bus does not show
        errSet[`BIE_E_CONTROL_TRANSMIT_CHECK_ERROR] = |((ctlOutFf ^ ctlIn) & ctlOutFf);
        errSet[`BIE_E_DROP] = (stFf == BIE_ARB) && opWrFf && busIn.arbDrop;
        errSet[`BIE_E_COL] = ((stFf == BIE_ARB) || busPhase) && busIn.arbCol;
        errSet[`BIE_E_TAGPE] = (stFf == BIE_LOOKUP) && tagErr;
        errSet[`BIE_E_STATPE] = (stFf == BIE_LOOKUP) && statErr;
        // another node answering our write data
        errSet[`BIE_E_SHR] = (stFf == BIE_XFER) && opWrFf && busIn.shared;
        errSet[`BIE_E_DRT] = (stFf == BIE_XFER) && opWrFf && busIn.dirty;
        // synchronisation losses during the write
        errSet[`BIE_E_STALL] = busPhase && opWrFf && busIn.stallErr;
        errSet[`BIE_E_CNFE] = busPhase && opWrFf && busIn.cnfErr;
        errSet[`BIE_E_CA] = busPhase && opWrFf && busIn.cmdAddrErr;
        // summary raised together with its cause
        errSet[`BIE_E_SUM] = errSet[`BIE_E_DROP] | errSet[`BIE_E_COL];
    end

    // next state of the request sequencer
    always_comb begin
        nxtSt = stFf;
        unique case (stFf)
            BIE_IDLE: begin
                // store-conditional looks up the cache first
                if (cpuReq.valid && cpuReq.store_conditional_request) begin
                    nxtSt = BIE_LOOKUP;
                end else if (cpuReq.valid && cpuReq.loadLock) begin
                    nxtSt = BIE_ARB;
                end
            end
            BIE_LOOKUP: begin
                if (cacheIn.stat[`BIE_LS_SHARED]) begin
                    nxtSt = BIE_ARB;
                end else begin
                    nxtSt = BIE_DONE;
                end
            end
            BIE_ARB: begin
                if (busIn.grant) begin
                    nxtSt = BIE_CMD;
                end
            end
            BIE_CMD: begin
                nxtSt = BIE_CNF;
            end
            BIE_CNF: begin
                if (busIn.confirm) begin
                    nxtSt = BIE_XFER;
                end
            end
            BIE_XFER: begin
                if (xferLast) begin
                    nxtSt = BIE_DONE;
                end
            end
            BIE_DONE: begin
                nxtSt = BIE_IDLE;
            end
            BIE_FAIL: begin
                nxtSt = BIE_IDLE;
            end
        endcase
        // any fatal error aborts the request
        if ((|errSet) && (stFf != BIE_IDLE) && (stFf != BIE_DONE)
            && (stFf != BIE_FAIL)) begin
            nxtSt = BIE_FAIL;
        end
    end

    // control lines driven in the next state
    always_comb begin
        nxtCtl = '0;
        nxtCtl[`BIE_CL_ARB] = (nxtSt == BIE_ARB);
        nxtCtl[`BIE_CL_CMD] = (nxtSt == BIE_CMD);
        nxtCtl[`BIE_CL_WR] = (nxtSt == BIE_CMD) && opWrFf;
        nxtCtl[`BIE_CL_DATA] = (nxtSt == BIE_XFER);
    end

    // sequencer registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stFf <= BIE_IDLE;
            opWrFf <= 1'b0;
            curAddrFf <= '0;
            cntFf <= 4'h0;
            ctlOutFf <= '0;
        end else begin
            stFf <= nxtSt;
            ctlOutFf <= nxtCtl;
            // latch the request on acceptance
            if ((stFf == BIE_IDLE) && cpuReq.valid) begin
                opWrFf <= cpuReq.store_conditional_request;
                curAddrFf <= cpuReq.addr;
            end
            // counter restarts on every state change
            if (nxtSt != stFf) begin
                cntFf <= 4'h0;
            end else if (cntFf != 4'hF) begin
                cntFf <= cntFf + 4'h1;
            end
        end
    end

    // acknowledge to the processor, one cycle per request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cackFf <= '0;
        end else begin
            cackFf.valid <= (stFf == BIE_DONE) || (stFf == BIE_FAIL);
            cackFf.hardErr <= (stFf == BIE_FAIL);
        end
    end

    // register access decode
    assign acc = (avs_read || avs_write) && !waitFf;
    assign clrBits = (acc && avs_write && (avs_address == `BIE_OFF_STATUS))
        ? avs_writedata[`BIE_ERR_W-1:0] : '0;
    assign clrHeld = acc && avs_write && (avs_address == `BIE_OFF_CAPSTATE)
        && avs_writedata[`BIE_CS_HELD];

    // sticky flags: set wins over a clear in the same cycle
    always_comb begin
        nxtStatus = (statusFf & ~clrBits) | errSet;
        // summary never stands without a drop or collision
        nxtStatus[`BIE_E_SUM] = nxtStatus[`BIE_E_SUM]
            & (nxtStatus[`BIE_E_DROP] | nxtStatus[`BIE_E_COL]);
    end

    // status and mask registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            statusFf <= '0;
            maskFf <= `BIE_MASK_RST;
        end else begin
            statusFf <= nxtStatus;
            if (acc && avs_write && (avs_address == `BIE_OFF_MASK)) begin
                maskFf <= avs_writedata[`BIE_ERR_W-1:0];
            end
        end
    end

    // capture of bus state; frozen until released by software
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            heldFf <= 1'b0;
            capAddrFf <= '0;
            capStFf <= 4'h0;
        end else if ((|errSet) && (!heldFf || clrHeld)) begin
            heldFf <= 1'b1;
            capAddrFf <= curAddrFf;
            capStFf <= {opWrFf, busIn.shared, busIn.dirty, 1'b0};
        end else if (clrHeld) begin
            heldFf <= 1'b0;
        end
    end

    // interrupt level from unmasked flags
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqFf <= 1'b0;
        end else begin
            irqFf <= |(statusFf & maskFf);
        end
    end

    // slave handshake: one wait cycle, then answer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            waitFf <= 1'b1;
            rdataFf <= 32'h0000_0000;
        end else begin
            waitFf <= !((avs_read || avs_write) && waitFf);
            if (avs_read && waitFf) begin
                unique case (avs_address)
                    `BIE_OFF_STATUS: rdataFf <= 32'(statusFf);
                    `BIE_OFF_MASK: rdataFf <= 32'(maskFf);
                    `BIE_OFF_CAPADDR: rdataFf <= 32'(capAddrFf);
                    `BIE_OFF_CAPSTATE: rdataFf <= {heldFf, 23'h0, 1'b0, stFf, capStFf};
                    // unmapped reads return zero
                    default: rdataFf <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign avs_readdata = rdataFf;
    assign avs_waitrequest = waitFf;
    assign cpuCack = cackFf;
    assign ctlOut = ctlOutFf;
    assign ctlOe = ctlOutFf;
    assign busAddr = curAddrFf;
    assign irq = irqFf;

    // checks of the detector behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    nxm_read_a: assert property ((stFf == BIE_CNF) && !opWrFf && cnfTimeout
        && !busIn.confirm |=> statusFf[`BIE_E_NXMRD] && (stFf == BIE_FAIL))
        else $error("unconfirmed read not flagged");
    addr_capture_a: assert property ((|errSet) && !heldFf
        |=> heldFf && (capAddrFf == $past(curAddrFf)))
        else $error("failing address not captured");
    cpe_hard_a: assert property (errSet[`BIE_E_CPE]
        |=> ##1 cackFf.valid && cackFf.hardErr)
        else $error("parity error without hard acknowledge");
    ctl_check_a: assert property (|((ctlOutFf ^ ctlIn) & ctlOutFf)
        |=> statusFf[`BIE_E_CONTROL_TRANSMIT_CHECK_ERROR])
        else $error("control mismatch not flagged");
    shared_write_a: assert property ((stFf == BIE_LOOKUP) && !tagErr && !statErr
        && cacheIn.stat[`BIE_LS_SHARED] && !(|errSet)
        |=> (stFf == BIE_ARB) && opWrFf && ctlOut[`BIE_CL_ARB])
        else $error("shared line did not start a bus write");
    arb_drop_a: assert property ((stFf == BIE_ARB) && opWrFf && busIn.arbDrop
        |=> statusFf[`BIE_E_DROP] && statusFf[`BIE_E_SUM])
        else $error("arbitration drop not flagged");
    arb_col_a: assert property (busPhase && busIn.arbCol
        |=> statusFf[`BIE_E_COL] && statusFf[`BIE_E_SUM])
        else $error("arbitration collision not flagged");
    tag_par_a: assert property ((stFf == BIE_LOOKUP) && tagErr
        |=> statusFf[`BIE_E_TAGPE] && (stFf == BIE_FAIL))
        else $error("tag parity not flagged");
    stat_par_a: assert property ((stFf == BIE_LOOKUP) && statErr
        |=> statusFf[`BIE_E_STATPE] && (stFf == BIE_FAIL))
        else $error("status parity not flagged");
    proto_err_a: assert property ((stFf == BIE_XFER) && opWrFf && busIn.dirty
        |=> statusFf[`BIE_E_DRT] && !ctlOut[`BIE_CL_DATA])
        else $error("dirty during write not flagged");
    sync_loss_a: assert property (busPhase && opWrFf && busIn.stallErr
        |=> statusFf[`BIE_E_STALL] ##1 cackFf.hardErr)
        else $error("stall error not flagged");
    summary_supp_a: assert property (statusFf[`BIE_E_SUM]
        |-> statusFf[`BIE_E_DROP] || statusFf[`BIE_E_COL])
        else $error("summary without supporting bit");
    nxm_write_a: assert property ((stFf == BIE_CNF) && opWrFf && cnfTimeout
        && !busIn.confirm |=> statusFf[`BIE_E_NXMWR]
        && (!statusFf[`BIE_E_NXMRD] || $past(statusFf[`BIE_E_NXMRD])))
        else $error("unconfirmed write not flagged");
    capture_hold_a: assert property (heldFf && !clrHeld
        |=> heldFf && $stable(capAddrFf) && $stable(capStFf))
        else $error("held capture overwritten");
    flag_hold_a: assert property (statusFf[`BIE_E_TAGPE] && !clrBits[`BIE_E_TAGPE]
        |=> statusFf[`BIE_E_TAGPE])
        else $error("sticky flag lost");

    sc_write_done_c: cover property ((stFf == BIE_XFER) && opWrFf ##[1:4] cackFf.valid);
    fail_ack_c: cover property (cackFf.valid && cackFf.hardErr);
    nxm_write_c: cover property (errSet[`BIE_E_NXMWR]);
    reg_read_c: cover property (acc && avs_read && (avs_address == `BIE_OFF_STATUS));
endmodule
`default_nettype wire

// file: design/bie_parity_chk.sv
// even parity checker over a stored field and its parity bit
// purely combinational; the caller qualifies the result
`timescale 1ns/1ps
`default_nettype none
module bie_parity_chk #(
    parameter int unsigned W = 8
) (
    input wire logic [W-1:0] data,
    input wire logic par,
    output logic err
);
    // odd count of ones over field plus parity is a failure
    assign err = ^{data, par};
endmodule
`default_nettype wire

// file: design/bie_pkg.sv
// types of the bus interface error detector
// relies on bie_defs.svh for every field width except the 3-bit state encoding
package bie_pkg;
`include "bie_defs.svh"
    // sequencer states
    typedef enum logic [2:0] {
        BIE_IDLE = 3'h0,
        BIE_LOOKUP = 3'h1,
        BIE_ARB = 3'h2,
        BIE_CMD = 3'h3,
        BIE_CNF = 3'h4,
        BIE_XFER = 3'h5,
        BIE_DONE = 3'h6,
        BIE_FAIL = 3'h7
    } bie_state_t;
    // processor request
    typedef struct packed {
        logic valid;
        logic loadLock;
        logic store_conditional_request;
        logic [`BIE_AW-1:0] addr;
    } bie_cpu_req_t;
    // cycle acknowledge back to the processor
    typedef struct packed {
        logic valid;
        logic hardErr;
    } bie_cycle_acknowledge_t;
    // backup cache lookup result
    typedef struct packed {
        logic [`BIE_TAG_W-1:0] tag;
        logic tagPar;
        logic [`BIE_STAT_W-1:0] stat;
        logic statPar;
    } bie_cache_t;
    // system bus responses and error reports
    typedef struct packed {
        logic grant;
        logic arbDrop;
        logic arbCol;
        logic confirm;
        logic cmdParErr;
        logic shared;
        logic dirty;
        logic stallErr;
        logic cnfErr;
        logic cmdAddrErr;
    } bie_bus_in_t;
endpackage

// file: tb/bie_bus_node.sv
// far side model: bus nodes that grant, confirm and inject faults
// assumes control lines idle low when nobody pulls them
`timescale 1ns/1ps
`default_nettype none
`include "bie_defs.svh"
module bie_bus_node
    import bie_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [`BIE_CTL_W-1:0] ctlOut,
    input wire logic [`BIE_CTL_W-1:0] ctlOe,
    input wire logic [3:0] grantDly,
    input wire logic [3:0] errSel,
    input wire logic noCnf,
    input wire logic [`BIE_CTL_W-1:0] dropMask,
    output var bie_bus_in_t busIn,
    output logic [`BIE_CTL_W-1:0] ctlIn
);
    logic [3:0] arbCnt_ff; // cycles spent requesting
    logic cmdSeen_ff; // command phase was last cycle
    logic busy; // any control line asserted
    // arbitration wait and command tracking
    always_ff @(posedge clk_sys) begin
        if (rst || !ctlOut[`BIE_CL_ARB]) begin
            arbCnt_ff <= 4'h0;
        end else if (arbCnt_ff != 4'hF) begin
            arbCnt_ff <= arbCnt_ff + 4'h1;
        end
        cmdSeen_ff <= !rst && ctlOut[`BIE_CL_CMD];
    end
    assign busy = |ctlOut;
    // responses and faults; an idle response reads low
    always_comb begin
        busIn = '0;
        busIn.grant = ctlOut[`BIE_CL_ARB] && arbCnt_ff >= grantDly;
        busIn.confirm = cmdSeen_ff && !noCnf;
        busIn.arbDrop = busy && errSel == 4'h1;
        busIn.arbCol = busy && errSel == 4'h2;
        busIn.cmdParErr = busy && errSel == 4'h3;
        busIn.shared = ctlOut[`BIE_CL_DATA] && errSel == 4'h4;
        busIn.dirty = ctlOut[`BIE_CL_DATA] && errSel == 4'h5;
        busIn.stallErr = busy && errSel == 4'h6;
        busIn.cnfErr = busy && errSel == 4'h7;
        busIn.cmdAddrErr = busy && errSel == 4'h8;
    end
    // wired lines; a faulty node may hold a driven line low
    assign ctlIn = ctlOut & ctlOe & ~dropMask;
endmodule
`default_nettype wire

// file: tb/bie_error_detect_test.sv
// self-checking bench of the bus interface error detector
// assumes the bus node model and a 250 MHz system clock
`timescale 1ns/1ps
`default_nettype none
`include "bie_defs.svh"
module bie_error_detect_test
    import bie_pkg::*;
;
    // one request case: stimulus and expected status
    typedef struct packed {
        logic sc;
        logic sh;
        logic tb;
        logic sb;
        logic [3:0] gd;
        logic [3:0] err;
        logic nc;
        logic dr;
        logic [13:0] exp;
    } bie_row_t;
    localparam bie_row_t ROWS [16] = '{
        '{1'h1, 1'h0, 1'h0, 1'h0, 4'h0, 4'h0, 1'h0, 1'h0, 14'h0000},
        '{1'h1, 1'h1, 1'h0, 1'h0, 4'h0, 4'h0, 1'h0, 1'h0, 14'h0000},
        '{1'h1, 1'h1, 1'h0, 1'h0, 4'h3, 4'h0, 1'h0, 1'h0, 14'h0000},
        '{1'h0, 1'h0, 1'h0, 1'h0, 4'h2, 4'h0, 1'h1, 1'h0, 14'h0001},
        '{1'h1, 1'h1, 1'h0, 1'h0, 4'h2, 4'h0, 1'h1, 1'h0, 14'h0002},
        '{1'h0, 1'h0, 1'h0, 1'h0, 4'h2, 4'h3, 1'h0, 1'h0, 14'h0004},
        '{1'h0, 1'h0, 1'h0, 1'h0, 4'h2, 4'h0, 1'h0, 1'h1, 14'h0008},
        '{1'h1, 1'h1, 1'h0, 1'h0, 4'h2, 4'h1, 1'h0, 1'h0, 14'h2010},
        '{1'h1, 1'h1, 1'h0, 1'h0, 4'h2, 4'h2, 1'h0, 1'h0, 14'h2020},
        '{1'h1, 1'h1, 1'h1, 1'h0, 4'h2, 4'h0, 1'h0, 1'h0, 14'h0040},
        '{1'h1, 1'h1, 1'h0, 1'h1, 4'h2, 4'h0, 1'h0, 1'h0, 14'h0080},
        '{1'h1, 1'h1, 1'h0, 1'h0, 4'h2, 4'h4, 1'h0, 1'h0, 14'h0100},
        '{1'h1, 1'h1, 1'h0, 1'h0, 4'h2, 4'h5, 1'h0, 1'h0, 14'h0200},
        '{1'h1, 1'h1, 1'h0, 1'h0, 4'h2, 4'h6, 1'h0, 1'h0, 14'h0400},
        '{1'h1, 1'h1, 1'h0, 1'h0, 4'h2, 4'h7, 1'h0, 1'h0, 14'h0800},
        '{1'h1, 1'h1, 1'h0, 1'h0, 4'h2, 4'h8, 1'h0, 1'h0, 14'h1000}
    };
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    bie_cpu_req_t cpuReq = '0;
    bie_cycle_acknowledge_t cpuCack;
    bie_cache_t cacheIn = '0;
    bie_bus_in_t busIn;
    logic [3:0] ctlIn;
    logic [3:0] ctlOut;
    logic [3:0] ctlOe;
    logic [31:0] busAddr;
    logic irq;
    logic [3:0] grantDly = 4'h0; // far side knobs
    logic [3:0] errSel = 4'h0;
    logic [3:0] dropMask = 4'h0;
    logic noCnf = 1'b0;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] rdat; // last read data
    logic hard; // hard error flag of last ack
    logic sawWr; // write command seen on the bus
    bie_row_t r;
    logic [31:0] a;
    bie_error_detect #(.CNF_TIMEOUT(`BIE_CNF_TIMEOUT), .XFER_CYCLES(`BIE_XFER_CYCLES))
    bie_error_detect_inst (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpuReq(cpuReq),
        .cpuCack(cpuCack), .cacheIn(cacheIn), .busIn(busIn), .ctlIn(ctlIn),
        .ctlOut(ctlOut), .ctlOe(ctlOe), .busAddr(busAddr), .irq(irq));
    bie_bus_node bie_bus_node_inst (.clk_sys(clk_sys), .rst(rst), .ctlOut(ctlOut),
        .ctlOe(ctlOe), .grantDly(grantDly), .errSel(errSel), .noCnf(noCnf),
        .dropMask(dropMask), .busIn(busIn), .ctlIn(ctlIn));
    // 4 ns clock
    always #2 clk_sys = ~clk_sys;
    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            conclude();
        end
    end
    // compare and report
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one register access, held until waitrequest is sampled low
    task automatic acc(input logic wr, input logic [4:0] ad, input logic [31:0] d);
        avs_address <= ad;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        // only the hang guard ends a wait that never answers
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    // one processor request, valid for a single idle cycle
    task automatic req(input logic sc, input logic [31:0] ad);
        sawWr = 1'b0;
        cpuReq <= '{valid: 1'b1, loadLock: !sc, store_conditional_request: sc, addr: ad};
        @(posedge clk_sys);
        cpuReq.valid <= 1'b0;
        do begin
            @(posedge clk_sys);
            sawWr |= ctlOut[`BIE_CL_WR];
        end while (cpuCack.valid !== 1'b1);
        hard = cpuCack.hardErr;
        @(posedge clk_sys);
    endtask
    // release status and capture
    task automatic clr();
        acc(1'b1, `BIE_OFF_STATUS, 32'h0000_3FFF);
        acc(1'b1, `BIE_OFF_CAPSTATE, 32'h8000_0000);
    endtask
    // verdict
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk("wait", 32'(avs_waitrequest), 32'h1);
        chk("idle", {cpuCack, ctlOe, irq}, 32'h0);
        chk("addr", busAddr, 32'h0);
        acc(1'b0, `BIE_OFF_MASK, 32'h0);
        chk("mask", rdat, 32'(`BIE_MASK_RST));
        acc(1'b0, `BIE_OFF_STATUS, 32'h0);
        chk("status", rdat, 32'h0);
        $display("reset test done");
        // table of request cases
        for (int i = 0; i < 16; i++) begin
            r = ROWS[i];
            a = 32'h4000_0000 + 32'(i) * 32'h10;
            clr();
            grantDly <= r.gd;
            errSel <= r.err;
            noCnf <= r.nc;
            dropMask <= {3'h0, r.dr};
            cacheIn <= '{16'h00A5, r.tb, {1'b0, r.sh, 1'b0}, r.sh ^ r.sb};
            req(r.sc, a);
            chk("hard", 32'(hard), 32'(|r.exp));
            chk("busaddr", busAddr, a);
            acc(1'b0, `BIE_OFF_STATUS, 32'h0);
            chk("status", rdat, 32'(r.exp));
            acc(1'b0, `BIE_OFF_CAPSTATE, 32'h0);
            chk("cap", rdat & 32'h8000_0006, {|r.exp, 28'h0, r.exp[8], r.exp[9], 1'b0});
            if (r.exp[1:0] != 2'h0) begin
                acc(1'b0, `BIE_OFF_CAPADDR, 32'h0);
                chk("capaddr", rdat, a);
            end
            if (r.exp == 14'h0) begin
                chk("buswrite", 32'(sawWr), 32'(r.sc & r.sh));
            end
            $display("row %0d done", i);
        end
        // held capture is not overwritten, then relatches
        clr();
        errSel <= 4'h0;
        noCnf <= 1'b1;
        req(1'b0, 32'h1111_0000);
        req(1'b0, 32'h2222_0000);
        acc(1'b0, `BIE_OFF_CAPADDR, 32'h0);
        chk("capaddr", rdat, 32'h1111_0000);
        acc(1'b0, `BIE_OFF_CAPSTATE, 32'h0);
        chk("held", rdat & 32'h8000_0000, 32'h8000_0000);
        acc(1'b1, `BIE_OFF_CAPSTATE, 32'h8000_0000);
        req(1'b0, 32'h3333_0000);
        acc(1'b0, `BIE_OFF_CAPADDR, 32'h0);
        chk("capaddr", rdat, 32'h3333_0000);
        $display("hold test done");
        // interrupt: masked, raised, cleared
        chk("irq", 32'(irq), 32'h0);
        acc(1'b1, `BIE_OFF_MASK, 32'h0000_0001);
        @(posedge clk_sys);
        chk("irq", 32'(irq), 32'h1);
        acc(1'b0, `BIE_OFF_MASK, 32'h0);
        chk("mask", rdat, 32'h0000_0001);
        acc(1'b1, `BIE_OFF_STATUS, 32'h0000_0001);
        @(posedge clk_sys);
        chk("irq", 32'(irq), 32'h0);
        $display("irq test done");
        // unmapped and read-only places
        acc(1'b0, 5'h10, 32'h0);
        chk("unmapped", rdat, 32'h0);
        acc(1'b1, `BIE_OFF_CAPADDR, 32'hFFFF_FFFF);
        acc(1'b0, `BIE_OFF_CAPADDR, 32'h0);
        chk("capaddr", rdat, 32'h3333_0000);
        $display("access test done");
        conclude();
    end
endmodule
`default_nettype wire
